// ==== core/tcw_pkg.sv ====
// Package: register map, field positions and modes for the channel-A waveform block
package tcw_pkg;
  // Register byte addresses on the AHB-Lite slave
  localparam logic [7:0] ADDR_CTRL_A = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B = 8'h04;
  localparam logic [7:0] ADDR_COMPARE = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  // Control register A fields
  localparam int COM_A_HI = 7;
  localparam int COM_A_LO = 6;
  localparam int COM_B_HI = 5;
  localparam int COM_B_LO = 4;
  localparam int WGM_HI = 1;
  localparam int WGM_LO = 0;
  localparam logic [7:0] CTRL_A_WMASK = 8'hF3;
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  // Control register B fields (own register): waveform_mode_high, port direction
  localparam int WGM_HIGH_BIT = 0;
  localparam int DIR_BIT = 1;
  localparam logic [1:0] CTRL_B_RESET = 2'h0;
  localparam logic [7:0] COMPARE_RESET = 8'h00;
  // waveform_mode_low encodings
  localparam logic [1:0] WGM_NORMAL = 2'h0;
  localparam logic [1:0] WGM_PHASE = 2'h1;
  localparam logic [1:0] WGM_CTC = 2'h2;
  localparam logic [1:0] WGM_FAST = 2'h3;
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  typedef enum logic [1:0] {TCW_NON_PWM, TCW_FAST_PWM, TCW_PHASE_PWM} tcw_wave_class_t;
endpackage

// ==== core/tcw_match.sv ====
// Compare-match and TOP event detector for one channel
`timescale 1ns/1ps
`default_nettype none
module tcw_match #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] count,
  input wire logic [WIDTH-1:0] compare,
  input wire logic [WIDTH-1:0] top,
  output logic match,
  output logic at_top
);
  assign match = (count == compare);
  assign at_top = (count == top);
endmodule
`default_nettype wire

// ==== core/tcw_wave_a.sv ====
// Channel-A compare-output waveform logic with AHB-Lite register slave
//
// Implementation choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Control A holds A mode at 7:6, B mode 5:4, waveform low 1:0; 3:2 read-only.
// - A nonzero A mode makes the pin follow the waveform, not the port, except PWM mode 1 with waveform high bit 0.
// - Pin driver enabled only when the port direction bit is also set.
// - Non-PWM: 0 disconnect, 1 toggle, 2 clear, 3 set on match.
// - PWM with mode 1: disconnected if waveform high bit 0, else toggle on match.
// - Fast PWM: 2 clears on match, sets at TOP; 3 the reverse.
// - Phase PWM mode 2: clear on up-count match, set on down-count match.
// - Phase PWM mode 3: set on up-count match, clear on down-count match.
// - PWM with compare equal TOP and upper mode bit: ignore match, act at TOP.
// - Mode field meaning depends on selected waveform-generation mode.
module tcw_wave_a #(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clk_en,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic [1:0] hresp,
  // Counter core side
  input wire logic [WIDTH-1:0] count,
  input wire logic count_down,
  input wire logic [WIDTH-1:0] count_top,
  input wire logic port_out,
  // Pin
  output logic pin_out,
  output logic pin_oe
);
  // ****************************************
  // Register slave
  // ****************************************
  logic [7:0] ctrl_a_q;
  logic [1:0] ctrl_b_q;
  logic [WIDTH-1:0] compare_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] rdata_q;
  logic wave_q;
  logic addr_ok;

  assign addr_ok = hsel && hready && htrans[1] && clk_en;
  assign hreadyout = 1'b1;
  assign hresp = tcw_pkg::HRESP_OKAY;
  assign hrdata = rdata_q;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else if (clk_en) begin
      wr_pend_q <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr_q <= haddr;
      end
    end else begin
      wr_pend_q <= 1'b0;
    end
  end

  // Read data captured in the address phase so it stands through the data phase
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      if (haddr == tcw_pkg::ADDR_CTRL_A) begin
        rdata_q <= {24'h00_0000, ctrl_a_q};
      end else if (haddr == tcw_pkg::ADDR_CTRL_B) begin
        rdata_q <= {30'h0000_0000, ctrl_b_q};
      end else if (haddr == tcw_pkg::ADDR_COMPARE) begin
        rdata_q <= {{(32 - WIDTH){1'b0}}, compare_q};
      end else if (haddr == tcw_pkg::ADDR_STATUS) begin
        rdata_q <= {30'h0000_0000, pin_oe, wave_q};
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl_a_q <= tcw_pkg::CTRL_A_RESET;
      ctrl_b_q <= tcw_pkg::CTRL_B_RESET;
      compare_q <= WIDTH'(tcw_pkg::COMPARE_RESET);
    end else if (clk_en && wr_pend_q) begin
      if (wr_addr_q == tcw_pkg::ADDR_CTRL_A) begin
        // Bits 3:2 are read-only and stay zero
        ctrl_a_q <= hwdata[7:0] & tcw_pkg::CTRL_A_WMASK;
      end else if (wr_addr_q == tcw_pkg::ADDR_CTRL_B) begin
        ctrl_b_q <= hwdata[1:0];
      end else if (wr_addr_q == tcw_pkg::ADDR_COMPARE) begin
        compare_q <= hwdata[WIDTH-1:0];
      end
    end
  end

  // ****************************************
  // Mode decode
  // ****************************************
  logic [1:0] chan_a_output_mode;
  logic [1:0] waveform_mode_low;
  logic waveform_mode_high;
  logic port_dir;
  tcw_pkg::tcw_wave_class_t wave_class;

  assign chan_a_output_mode = ctrl_a_q[tcw_pkg::COM_A_HI:tcw_pkg::COM_A_LO];
  assign waveform_mode_low = ctrl_a_q[tcw_pkg::WGM_HI:tcw_pkg::WGM_LO];
  assign waveform_mode_high = ctrl_b_q[tcw_pkg::WGM_HIGH_BIT];
  assign port_dir = ctrl_b_q[tcw_pkg::DIR_BIT];

  always_comb begin
    case (waveform_mode_low)
      tcw_pkg::WGM_FAST: wave_class = tcw_pkg::TCW_FAST_PWM;
      tcw_pkg::WGM_PHASE: wave_class = tcw_pkg::TCW_PHASE_PWM;
      default: wave_class = tcw_pkg::TCW_NON_PWM;
    endcase
  end

  // ****************************************
  // Compare events
  // ****************************************
  logic match_raw;
  logic at_top;
  logic is_pwm;
  logic match_eff;
  logic connected;

  tcw_match #(.WIDTH(WIDTH)) tcw_match_i (
    .count(count),
    .compare(compare_q),
    .top(count_top),
    .match(match_raw),
    .at_top(at_top)
  );

  assign is_pwm = (wave_class != tcw_pkg::TCW_NON_PWM);
  // In PWM, compare equal to TOP with the upper mode bit set: TOP action alone decides
  assign match_eff = match_raw &&
                     !(is_pwm && chan_a_output_mode[1] && compare_q == count_top);
  // PWM mode 1 is only live when the high waveform bit is set
  assign connected = (chan_a_output_mode != 2'h0) &&
                     !(is_pwm && chan_a_output_mode == 2'h1 && !waveform_mode_high);

  // ****************************************
  // Waveform register
  // ****************************************
  logic wave_d;

  always_comb begin
    wave_d = wave_q;
    if (connected) begin
      if (chan_a_output_mode == 2'h1) begin
        if (match_eff) begin
          wave_d = !wave_q;
        end
      end else begin
        case (wave_class)
          tcw_pkg::TCW_NON_PWM: begin
            if (match_eff) begin
              wave_d = chan_a_output_mode[0];
            end
          end
          tcw_pkg::TCW_FAST_PWM: begin
            if (match_eff) begin
              wave_d = chan_a_output_mode[0];
            end else if (at_top) begin
              wave_d = !chan_a_output_mode[0];
            end
          end
          tcw_pkg::TCW_PHASE_PWM: begin
            if (match_eff) begin
              wave_d = chan_a_output_mode[0] ^ count_down;
            end else if (at_top && chan_a_output_mode[1] && compare_q == count_top) begin
              // Set or clear at TOP as a down-count match would
              wave_d = !chan_a_output_mode[0];
            end
          end
          default: wave_d = wave_q;
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wave_q <= 1'b0;
    end else if (clk_en) begin
      wave_q <= wave_d;
    end
  end

  // ****************************************
  // Pin mux
  // ****************************************
  // Disconnected output, PWM mode 1 with the high bit clear included, hands the pin back
  assign pin_out = connected ? wave_q : port_out;
  assign pin_oe = port_dir;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_fast_clear_match;
    wave_class == tcw_pkg::TCW_FAST_PWM && chan_a_output_mode == 2'h2 && match_eff && clk_en;
  endsequence

  sequence s_nonpwm_match;
    wave_class == tcw_pkg::TCW_NON_PWM && match_eff && clk_en;
  endsequence

  property p_ctrl_ro;
    @(posedge mclk) disable iff (!nrst) ctrl_a_q[3:2] == 2'h0;
  endproperty
  a_ctrl_ro: assert property (p_ctrl_ro) else $error("read-only bits set");

  property p_pin_wave;
    @(posedge mclk) disable iff (!nrst) connected |-> pin_out == wave_q;
  endproperty
  a_pin_wave: assert property (p_pin_wave) else $error("pin not on waveform");

  property p_pin_port;
    @(posedge mclk) disable iff (!nrst) !connected |-> pin_out == port_out;
  endproperty
  a_pin_port: assert property (p_pin_port) else $error("pin not on port");

  property p_oe;
    @(posedge mclk) disable iff (!nrst) pin_oe == port_dir;
  endproperty
  a_oe: assert property (p_oe) else $error("driver enable wrong");

  property p_nonpwm_toggle;
    @(posedge mclk) disable iff (!nrst)
      wave_class == tcw_pkg::TCW_NON_PWM && chan_a_output_mode == 2'h1 && match_raw && clk_en
      |=> wave_q != $past(wave_q);
  endproperty
  a_nonpwm_toggle: assert property (p_nonpwm_toggle) else $error("no toggle");

  property p_nonpwm_set;
    @(posedge mclk) disable iff (!nrst)
      chan_a_output_mode == 2'h3 ##0 s_nonpwm_match |=> wave_q == 1'b1;
  endproperty
  a_nonpwm_set: assert property (p_nonpwm_set) else $error("non-PWM set failed");

  property p_nonpwm_clear;
    @(posedge mclk) disable iff (!nrst)
      chan_a_output_mode == 2'h2 ##0 s_nonpwm_match |=> wave_q == 1'b0;
  endproperty
  a_nonpwm_clear: assert property (p_nonpwm_clear) else $error("non-PWM clear failed");

  property p_pwm_disc;
    @(posedge mclk) disable iff (!nrst)
      is_pwm && chan_a_output_mode == 2'h1 && !waveform_mode_high |=> $stable(wave_q);
  endproperty
  a_pwm_disc: assert property (p_pwm_disc) else $error("disconnected output moved");

  property p_fast_clear;
    @(posedge mclk) disable iff (!nrst) s_fast_clear_match |=> !wave_q;
  endproperty
  a_fast_clear: assert property (p_fast_clear) else $error("fast clear failed");

  property p_fast_set_top;
    @(posedge mclk) disable iff (!nrst)
      wave_class == tcw_pkg::TCW_FAST_PWM && chan_a_output_mode == 2'h2 && at_top
      && !match_eff && clk_en |=> wave_q == 1'b1;
  endproperty
  a_fast_set_top: assert property (p_fast_set_top) else $error("fast set at TOP failed");

  property p_fast_clr_top;
    @(posedge mclk) disable iff (!nrst)
      wave_class == tcw_pkg::TCW_FAST_PWM && chan_a_output_mode == 2'h3 && at_top
      && !match_eff && clk_en |=> wave_q == 1'b0;
  endproperty
  a_fast_clr_top: assert property (p_fast_clr_top) else $error("fast clear at TOP failed");

  property p_phase_up2;
    @(posedge mclk) disable iff (!nrst)
      wave_class == tcw_pkg::TCW_PHASE_PWM && chan_a_output_mode == 2'h2 && match_eff
      && clk_en |=> wave_q == $past(count_down);
  endproperty
  a_phase_up2: assert property (p_phase_up2) else $error("phase mode 2 wrong");

  property p_phase_up3;
    @(posedge mclk) disable iff (!nrst)
      wave_class == tcw_pkg::TCW_PHASE_PWM && chan_a_output_mode == 2'h3 && match_eff
      && clk_en |=> wave_q == !$past(count_down);
  endproperty
  a_phase_up3: assert property (p_phase_up3) else $error("phase mode 3 wrong");

  property p_phase_top;
    @(posedge mclk) disable iff (!nrst)
      wave_class == tcw_pkg::TCW_PHASE_PWM && chan_a_output_mode == 2'h3 && at_top
      && compare_q == count_top && clk_en |=> wave_q == 1'b0;
  endproperty
  a_phase_top: assert property (p_phase_top) else $error("phase TOP action wrong");

  property p_top_ignore;
    @(posedge mclk) disable iff (!nrst)
      is_pwm && chan_a_output_mode[1] && compare_q == count_top |-> !match_eff;
  endproperty
  a_top_ignore: assert property (p_top_ignore) else $error("match at TOP not ignored");
endmodule
`default_nettype wire

// ==== bench/tcw_wave_a_tb.sv ====
// Self-checking testbench for the channel-A compare-output waveform block
`timescale 1ns/1ps
`default_nettype none
module tcw_wave_a_tb;
  typedef struct packed {
    logic [1:0] m;
    logic [1:0] wl;
    logic hi;
    logic [7:0] c;
    logic dn;
    logic ex;
  } tcw_step_t;
  localparam logic [1:0] NO = tcw_pkg::WGM_NORMAL;
  localparam logic [1:0] CT = tcw_pkg::WGM_CTC;
  localparam logic [1:0] FA = tcw_pkg::WGM_FAST;
  localparam logic [1:0] PH = tcw_pkg::WGM_PHASE;
  localparam logic [7:0] TOPV = 8'hF0;
  localparam logic [7:0] IDLEV = 8'h10;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic [1:0] hresp;
  logic [7:0] count = IDLEV;
  logic count_down = 1'b0;
  logic port_out = 1'b0;
  logic pin_out;
  logic pin_oe;
  logic rd_dp = 1'b0;
  logic pin_chk = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] exp_v;
  logic [31:0] got;
  logic [31:0] r;
  int err_total = 0;
  int comparisons = 0;
  // Steps run in order; each expectation builds on the wave level left by the one before
  tcw_step_t steps[19] = '{
    '{2'h2, NO, 1'b0, 8'h80, 1'b0, 1'b0}, '{2'h3, CT, 1'b0, 8'h80, 1'b0, 1'b1},
    '{2'h1, NO, 1'b0, 8'h80, 1'b0, 1'b0}, '{2'h1, CT, 1'b0, 8'h80, 1'b0, 1'b1},
    '{2'h2, FA, 1'b0, 8'h80, 1'b0, 1'b0}, '{2'h2, FA, 1'b0, TOPV, 1'b0, 1'b1},
    '{2'h3, FA, 1'b0, TOPV, 1'b0, 1'b0}, '{2'h3, FA, 1'b0, 8'h80, 1'b0, 1'b1},
    '{2'h1, FA, 1'b0, 8'h80, 1'b0, 1'b0}, '{2'h1, FA, 1'b1, 8'h80, 1'b0, 1'b0},
    '{2'h1, PH, 1'b1, 8'h80, 1'b0, 1'b1}, '{2'h2, PH, 1'b0, 8'h80, 1'b0, 1'b0},
    '{2'h2, PH, 1'b0, 8'h80, 1'b1, 1'b1}, '{2'h3, PH, 1'b0, 8'h80, 1'b1, 1'b0},
    '{2'h3, PH, 1'b0, 8'h80, 1'b0, 1'b1}, '{2'h3, FA, 1'b0, TOPV, 1'b0, 1'b0},
    '{2'h2, FA, 1'b0, TOPV, 1'b0, 1'b1}, '{2'h3, PH, 1'b0, TOPV, 1'b0, 1'b0},
    '{2'h3, NO, 1'b0, TOPV, 1'b0, 1'b1}};
  always #50 mclk = ~mclk;
  tcw_wave_a #(.WIDTH(8)) tcw_wave_a_i (.mclk(mclk), .nrst(nrst), .clk_en(clk_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .count(count), .count_down(count_down), .count_top(TOPV),
    .port_out(port_out), .pin_out(pin_out), .pin_oe(pin_oe));
  // Result watcher: read data at the end of a data phase, or the pin when asked
  always @(posedge mclk) begin
    if (((rd_dp && hreadyout === 1'b1) || pin_chk) && exp_q.size() > 0) begin
      exp_v = exp_q.pop_front();
      got = rd_dp ? hrdata : {30'h0, pin_oe, pin_out};
      comparisons++;
      if (got !== exp_v) begin
        err_total++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp_v);
      end
    end
  end
  task automatic end_sim();
    if (err_total == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge mclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        err_total++;
        end_sim();
      end
      @(posedge mclk);
    end
  endtask
  // For a read, d is the expected data
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wr ? d : 32'h0;
    rd_dp <= ~wr;
    if (!wr) begin
      exp_q.push_back(d);
    end
    wait_rdy();
    rd_dp <= 1'b0;
  endtask
  task automatic chk_pin(input logic oe, input logic v);
    exp_q.push_back({30'h0, oe, v});
    pin_chk <= 1'b1;
    @(posedge mclk);
    pin_chk <= 1'b0;
  endtask
  // One cycle of count at v, then back to a value that is neither compare nor TOP
  task automatic hit(input logic [7:0] v, input logic dn);
    count <= v;
    count_down <= dn;
    @(posedge mclk);
    count <= IDLEV;
    @(posedge mclk);
  endtask
  task automatic cfg(input tcw_step_t s);
    bus(1'b1, tcw_pkg::ADDR_CTRL_A, {24'h0, s.m, 4'h0, s.wl});
    bus(1'b1, tcw_pkg::ADDR_CTRL_B, {30'h0, 1'b1, s.hi});
  endtask
  initial begin
    void'($urandom(94328));
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    chk_pin(1'b0, 1'b0);
    bus(1'b0, tcw_pkg::ADDR_CTRL_A, {24'h0, tcw_pkg::CTRL_A_RESET});
    bus(1'b0, tcw_pkg::ADDR_CTRL_B, 32'h0);
    bus(1'b0, 8'h40, 32'h0);
    r = $urandom;
    port_out <= r[8];
    bus(1'b1, tcw_pkg::ADDR_CTRL_A, r);
    bus(1'b0, tcw_pkg::ADDR_CTRL_A, {24'h0, r[7:0] & tcw_pkg::CTRL_A_WMASK});
    cfg('{2'h0, NO, 1'b0, 8'h00, 1'b0, 1'b0});
    chk_pin(1'b1, r[8]);
    bus(1'b1, tcw_pkg::ADDR_COMPARE, 32'h80);
    // Port level is low so a disconnected pin shows the port, not the held wave level
    port_out <= 1'b0;
    foreach (steps[i]) begin
      if (i == 15) begin
        bus(1'b1, tcw_pkg::ADDR_COMPARE, {24'h0, TOPV});
      end
      cfg(steps[i]);
      hit(steps[i].c, steps[i].dn);
      chk_pin(1'b1, steps[i].ex);
    end
    // Clock enable low: a match must leave the wave register alone
    bus(1'b1, tcw_pkg::ADDR_CTRL_A, {24'h0, 2'h2, 4'h0, NO});
    clk_en <= 1'b0;
    hit(TOPV, 1'b0);
    clk_en <= 1'b1;
    chk_pin(1'b1, 1'b1);
    bus(1'b1, tcw_pkg::ADDR_CTRL_B, 32'h0);
    chk_pin(1'b0, 1'b1);
    bus(1'b0, tcw_pkg::ADDR_STATUS, 32'h1);
    // Let the watcher take the last result before the verdict
    @(posedge mclk);
    if (exp_q.size() != 0) begin
      err_total++;
      $display("wrong value at %0t: %0d results never seen", $time, exp_q.size());
    end
    end_sim();
  end
endmodule
`default_nettype wire
